/* File: hdl/dcd_defines.svh */
// Constants for the divide-by-three / divide-by-five clock divider.
// Assumes a single core clock that samples the divided input clock as a pin.
// What this block does
// - The output runs at one third of the input clock rate with ratio select low and one fifth with it high.
// - With enable low and clear inactive the true output is low and the complement high, whatever the ratio.
// - Enable is sampled on an input rising edge and the output starts or stops only at the next falling edge.
// - Master clear low forces the true output low and the complement high at once, over enable and ratio.
// - Enable, master clear and ratio select read as high out of reset; nothing holds an undriven pin high after that.
// - Dividing by three, the high part of each output period lies between 45 and 55 percent of it.
// - Dividing by five, the high part of each output period lies between 47 and 53 percent of it.
`ifndef DCD_DEFINES_SVH
`define DCD_DEFINES_SVH

// Output period in input half periods is twice the half count
`define DCD_HALF_DIV3 4'h3
`define DCD_HALF_DIV5 4'h5
`define DCD_LAST_DIV3 4'h5
`define DCD_LAST_DIV5 4'h9
`define DCD_PHASE_ZERO 4'h0
`define DCD_PHASE_STEP 4'h1

// Pin group order {in_p, in_n, enable, master_clear_n, div_sel}
`define DCD_PIN_WIDTH 5
`define DCD_SYNC_RST 5'h07

// Core clock period in ns; the input clock must stay below about a quarter of this rate
`define DCD_CORE_PERIOD_NS 40

`endif

/* File: hdl/dcd_pkg.sv */
// Types shared by the clock divider files.
// Assumes nothing beyond the defines header.
package dcd_pkg;

    typedef struct packed {
        logic enable;
        logic master_clear_n;
        logic div_sel;
    } dcd_ctrl_type;

    typedef enum logic [1:0] {
        DCD_OFF = 2'b01,
        DCD_ON = 2'b10
    } dcd_state_type;

endpackage

/* File: hdl/dcd_sync.sv */
// Two-stage synchroniser for the divider's pin group.
// Assumes every input bit is asynchronous to core_clk.
`timescale 1ns/100ps
`include "dcd_defines.svh"
module dcd_sync (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [`DCD_PIN_WIDTH-1:0] pin_raw,
    output logic [`DCD_PIN_WIDTH-1:0] pin_sync
);
    import dcd_pkg::*;

    localparam logic [`DCD_PIN_WIDTH-1:0] RST_VAL = `DCD_SYNC_RST;
    logic [`DCD_PIN_WIDTH-1:0] stage1_reg;
    logic [`DCD_PIN_WIDTH-1:0] stage2_reg;

    genvar i;
    generate
        for (i = 0; i < `DCD_PIN_WIDTH; i = i + 1) begin : g_bit
            // Control bits come out of reset high, as an unconnected pin would read
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    stage1_reg[i] <= RST_VAL[i];
                    stage2_reg[i] <= RST_VAL[i];
                end else begin
                    stage1_reg[i] <= pin_raw[i];
                    stage2_reg[i] <= stage1_reg[i];
                end
            end
        end
    endgenerate

    assign pin_sync = stage2_reg;

endmodule

/* File: hdl/dcd_divider.sv */
// Divide-by-three / divide-by-five clock divider with enable and master clear.
// Assumes the differential input clock is sampled by core_clk and is slow enough
// that each input half period spans several core_clk cycles.
`timescale 1ns/100ps
`include "dcd_defines.svh"
module dcd_divider (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_clk_p,
    input wire logic in_clk_n,
    input wire dcd_pkg::dcd_ctrl_type ctrl,
    output logic q_out,
    output logic q_n_out
);
    import dcd_pkg::*;

    logic [`DCD_PIN_WIDTH-1:0] pin_raw;
    logic [`DCD_PIN_WIDTH-1:0] pin_sync;
    logic s_p;
    logic s_n;
    logic s_en;
    logic s_mr;
    logic s_sel;
    logic clear_active;

    assign pin_raw = {in_clk_p, in_clk_n, ctrl.enable, ctrl.master_clear_n, ctrl.div_sel};

    dcd_sync u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_raw(pin_raw),
        .pin_sync(pin_sync)
    );

    assign s_p = pin_sync[4];
    assign s_n = pin_sync[3];
    assign s_en = pin_sync[2];
    assign s_mr = pin_sync[1];
    assign s_sel = pin_sync[0];
    assign clear_active = ~s_mr;

    // Input edge detection on the differential pair
    logic lvl_reg;
    logic lvl_next;
    logic rise;
    logic fall;

    always_comb begin
        lvl_next = lvl_reg;
        // An equal pair carries no level; hold the last one rather than invent an edge
        if (s_p != s_n) begin
            lvl_next = s_p;
        end
        rise = lvl_next & ~lvl_reg;
        fall = ~lvl_next & lvl_reg;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lvl_reg <= 1'b0;
        end else begin
            lvl_reg <= lvl_next;
        end
    end

    // Divider state: run state, enable pending, phase counter, latched ratio, output
    dcd_state_type state_reg;
    dcd_state_type state_next;
    logic pend_reg;
    logic pend_next;
    logic [3:0] phase_reg;
    logic [3:0] phase_next;
    logic sel_reg;
    logic sel_next;
    logic q_reg;
    logic q_next;
    logic [3:0] half;
    logic [3:0] last;
    logic [3:0] phase_inc;

    always_comb begin
        state_next = state_reg;
        pend_next = pend_reg;
        phase_next = phase_reg;
        sel_next = sel_reg;
        q_next = q_reg;
        half = sel_reg ? `DCD_HALF_DIV5 : `DCD_HALF_DIV3;
        last = sel_reg ? `DCD_LAST_DIV5 : `DCD_LAST_DIV3;
        phase_inc = phase_reg + `DCD_PHASE_STEP;
        if (clear_active) begin
            state_next = DCD_OFF;
            pend_next = 1'b0;
            phase_next = `DCD_PHASE_ZERO;
            sel_next = s_sel;
            q_next = 1'b0;
        end else begin
            if (rise) begin
                pend_next = s_en;
            end
            case (state_reg)
                DCD_OFF: begin
                    q_next = 1'b0;
                    if (fall && pend_reg) begin
                        state_next = DCD_ON;
                        phase_next = `DCD_PHASE_ZERO;
                        sel_next = s_sel;
                        q_next = 1'b1;
                    end
                end
                DCD_ON: begin
                    if (fall && !pend_reg) begin
                        // Stopping may cut the current high phase short
                        state_next = DCD_OFF;
                        phase_next = `DCD_PHASE_ZERO;
                        q_next = 1'b0;
                    end else if (rise || fall) begin
                        // Both input edges count, so the high time is exactly half the period
                        if (phase_reg == last) begin
                            phase_next = `DCD_PHASE_ZERO;
                            sel_next = s_sel;
                            q_next = 1'b1;
                        end else begin
                            phase_next = phase_inc;
                            q_next = (phase_inc < half);
                        end
                    end
                end
                default: begin
                    state_next = DCD_OFF;
                    phase_next = `DCD_PHASE_ZERO;
                    q_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= DCD_OFF;
            pend_reg <= 1'b0;
            phase_reg <= `DCD_PHASE_ZERO;
            sel_reg <= 1'b1;
            q_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pend_reg <= pend_next;
            phase_reg <= phase_next;
            sel_reg <= sel_next;
            q_reg <= q_next;
        end
    end

    // The raw pin gates the output so a clear needs no clock edge
    assign q_out = q_reg & ctrl.master_clear_n;
    assign q_n_out = ~q_out;

    // Checks

    off_output_low_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == DCD_OFF) |-> (!q_out && q_n_out))
        else $error("output not parked while divider is off");

    clear_forces_a: assert property (@(posedge core_clk) disable iff (rst)
        !ctrl.master_clear_n |-> (!q_out && q_n_out))
        else $error("master clear did not force the outputs");

    phase_bound_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == DCD_ON) |-> (phase_reg <= (sel_reg ? `DCD_LAST_DIV5 : `DCD_LAST_DIV3)))
        else $error("phase counter ran past the period");

    start_on_fall_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(state_reg == DCD_ON) |-> ($past(fall) && $past(pend_reg) && q_reg))
        else $error("output started without a rising then falling edge");

    stop_on_fall_a: assert property (@(posedge core_clk) disable iff (rst)
        ($fell(state_reg == DCD_ON) && $past(s_mr)) |-> ($past(fall) && !$past(pend_reg)))
        else $error("output stopped away from a falling edge");

    duty_div3_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == DCD_ON && !sel_reg) |-> (q_reg == (phase_reg < `DCD_HALF_DIV3)))
        else $error("divide by three high time is not half the period");

    duty_div5_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == DCD_ON && sel_reg) |-> (q_reg == (phase_reg < `DCD_HALF_DIV5)))
        else $error("divide by five high time is not half the period");

    pins_default_a: assert property (@(posedge core_clk)
        $fell(rst) |-> (s_en && s_mr && s_sel))
        else $error("control pins do not default high after reset");

    clear_restart_a: assert property (@(posedge core_clk) disable iff (rst)
        clear_active |=> (phase_reg == `DCD_PHASE_ZERO && state_reg == DCD_OFF))
        else $error("clear did not restart the divider");

    ratio_at_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
        ($changed(sel_reg) && $past(s_mr) && $past(state_reg == DCD_ON)) |-> (phase_reg == `DCD_PHASE_ZERO))
        else $error("ratio changed away from a counter wrap");

    ratio_held_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == DCD_ON && phase_reg != `DCD_PHASE_ZERO) |-> $stable(sel_reg))
        else $error("ratio changed in the middle of a period");

    clear_pend_a: assert property (@(posedge core_clk) disable iff (rst)
        clear_active |=> !pend_reg)
        else $error("clear left an enable pending");

    enable_latch_a: assert property (@(posedge core_clk) disable iff (rst)
        (rise && !clear_active) |=> (pend_reg == $past(s_en)))
        else $error("enable not taken at an input rising edge");

    pend_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        (!rise && !clear_active) |=> $stable(pend_reg))
        else $error("pending enable moved away from a rising edge");

    off_until_fall_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == DCD_OFF && !fall) |=> (state_reg == DCD_OFF))
        else $error("divider started away from a falling edge");

    phase_step_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == DCD_ON && !clear_active && rise && phase_reg != last) |=> (phase_reg == $past(phase_reg) + 4'h1))
        else $error("phase counter did not advance on an input edge");

endmodule

/* File: testbench/dcd_src.sv */
// Clock source model driving the divider's differential input pair.
// Assumes core_clk is the bench clock; half counts its cycles per input half period.
`timescale 1ns/100ps
module dcd_src (
    input wire logic core_clk,
    input wire logic [3:0] half,
    output logic in_clk_p,
    output logic in_clk_n
);
    logic [3:0] cnt_reg = 4'h0;
    logic lvl_reg = 1'b0;
    // Both legs always driven and opposite, so the pair never floats
    assign in_clk_p = lvl_reg;
    assign in_clk_n = ~lvl_reg;
    always @(posedge core_clk) begin
        if (cnt_reg >= half - 4'h1) begin
            cnt_reg <= 4'h0;
            lvl_reg <= ~lvl_reg;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the clock divider: pulse widths, enable, clear, ratio.
// Assumes dcd_src feeds the input pair and core_clk runs at 25 MHz.
`timescale 1ns/100ps
module tb_top;
    import dcd_pkg::*;
    logic core_clk, rst, in_clk_p, in_clk_n, q_out, q_n_out, sel, old;
    logic [3:0] half;
    dcd_ctrl_type ctrl;
    int failures, compares, hi, lo;
    dcd_src SRC (.core_clk(core_clk), .half(half), .in_clk_p(in_clk_p), .in_clk_n(in_clk_n));
    dcd_divider DUT (.core_clk(core_clk), .rst(rst), .in_clk_p(in_clk_p), .in_clk_n(in_clk_n),
        .ctrl(ctrl), .q_out(q_out), .q_n_out(q_n_out));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    function automatic int pulse(logic s);
        return (s ? 5 : 3) * int'(half);
    endfunction
    task automatic check(string what, int e, int s);
        compares++;
        if (s > e + 1 || s < e - 1) begin
            failures++;
            $display("wrong value %s expected %0d seen %0d", what, e, s);
        end
    endtask
    task automatic check_bit(string what, logic e, logic s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, e, s);
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic drive(logic en, logic mr, logic s);
        @(posedge core_clk);
        #1;
        ctrl = '{enable: en, master_clear_n: mr, div_sel: s};
    endtask
    // Sampled on falling core edges so the output has settled
    task automatic measure(logic align);
        hi = 0;
        lo = 0;
        while (align && q_out === 1'b1 && lo < 400) begin
            @(negedge core_clk);
            lo++;
        end
        while (align && q_out !== 1'b1 && hi < 400) begin
            @(negedge core_clk);
            hi++;
        end
        hi = 0;
        lo = 0;
        while (q_out === 1'b1 && hi < 400) begin
            @(negedge core_clk);
            hi++;
        end
        while (q_out !== 1'b1 && lo < 400) begin
            @(negedge core_clk);
            lo++;
        end
    endtask
    always @(negedge core_clk) begin
        if (!rst) begin
            check_bit("q_n_out", ~q_out, q_n_out);
        end
    end
    initial begin
        #(40 * 20000);
        failures++;
        stop_test();
    end
    initial begin
        failures = 0;
        compares = 0;
        void'($urandom(32'hCC4F));
        rst = 1'b1;
        half = 4'h6;
        ctrl = '{enable: 1'b1, master_clear_n: 1'b1, div_sel: 1'b1};
        repeat (3) @(posedge core_clk);
        #1;
        rst = 1'b0;
        check_bit("q_out", 1'b0, q_out);
        // Control pins held high as if left open
        measure(1'b1);
        check("div5 high", pulse(1'b1), hi);
        check("div5 low", pulse(1'b1), lo);
        for (int i = 0; i < 8; i++) begin
            half = 4'h5 + 4'($urandom_range(4));
            // First two passes force a change to divide by three and back
            sel = (i < 2) ? 1'(i) : 1'($urandom_range(1));
            old = ctrl.div_sel;
            measure(1'b1);
            drive(1'b1, 1'b1, sel);
            measure(1'b0);
            check("pulse before wrap", pulse(old), hi);
            check("low before wrap", pulse(old), lo);
            measure(1'b0);
            check("high", pulse(sel), hi);
            check("low", pulse(sel), lo);
        end
        half = 4'h6;
        drive(1'b1, 1'b1, 1'b1);
        measure(1'b1);
        measure(1'b1);
        drive(1'b0, 1'b1, 1'b1);
        repeat (6) @(negedge core_clk);
        check_bit("q_out before fall", 1'b1, q_out);
        repeat (9) @(negedge core_clk);
        check_bit("q_out stopped", 1'b0, q_out);
        for (int i = 0; i < 4; i++) begin
            repeat (10) @(negedge core_clk);
            check_bit("q_out held", 1'b0, q_out);
        end
        drive(1'b1, 1'b1, 1'b1);
        measure(1'b1);
        check("restart high", pulse(1'b1), hi);
        measure(1'b1);
        drive(1'b1, 1'b0, 1'b0);
        #1;
        check_bit("q_out cleared", 1'b0, q_out);
        check_bit("q_n_out cleared", 1'b1, q_n_out);
        repeat (20) @(negedge core_clk);
        check_bit("q_out in clear", 1'b0, q_out);
        drive(1'b1, 1'b1, 1'b1);
        measure(1'b1);
        check("after clear", pulse(1'b1), hi);
        stop_test();
    end
endmodule
